/* design/pvc_pkg.sv */
// shared constants and types for the paged register and video port control block
package pvc_pkg;
	// register map: page select sits at the same offset in every page
	localparam logic [7:0] PAGE_SEL_OFF = 8'hF0;
	localparam logic [7:0] CTRL_OFF = 8'h08; // output control word, colour page
	localparam logic [7:0] STATUS_OFF = 8'h0E; // status word, sensor page
	localparam int BANK_WORDS = 8; // plain storage words per page at 0x00..0x07
	// page numbers
	localparam logic [1:0] PAGE_SENSOR = 2'h0;
	localparam logic [1:0] PAGE_COLOR = 2'h1;
	localparam logic [1:0] PAGE_CAMCTL = 2'h2;
	localparam logic [15:0] PAGE_LIMIT = 16'h0003; // page values at or above are ignored
	// control word fields
	localparam int CF_FMT = 0; // three bits of output format
	localparam int FMT_W = 3;
	localparam int CF_W10 = 3; // 1: ten-bit port
	localparam int CF_UNI = 4; // 1: pixel clock runs continuously
	localparam int CF_TRI = 5; // 1: outputs tri-stated
	localparam int CF_SLP = 6; // 1: standby
	localparam int CF_EMB = 7; // 1: sync markers embedded
	localparam int CTRL_W = 8;
	localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
	// output formats
	localparam logic [2:0] FMT_YCC = 3'h0;
	localparam logic [2:0] FMT_565 = 3'h1;
	localparam logic [2:0] FMT_555 = 3'h2;
	localparam logic [2:0] FMT_444 = 3'h3;
	localparam logic [2:0] FMT_RAW = 3'h4;
	localparam logic [2:0] FMT_PBAY = 3'h5;
	// video pipeline and marker timing in beats of two link clocks, marker bytes, serial bit counts
	localparam int DLY = 5;
	localparam logic [2:0] MK_LEN = 3'h4;
	localparam logic [7:0] MK_FF = 8'hFF;
	localparam logic [7:0] MK_00 = 8'h00;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// samples offered by the imaging pipeline on the link clock
	typedef struct packed {
		logic frame;
		logic line;
		logic [9:0] raw;
		logic [23:0] rgb;
		logic [7:0] ycc;
	} pvc_src_s;
	// parallel video port, all from flip-flops
	typedef struct packed {
		logic oe_n;
		logic pclk;
		logic frame;
		logic line;
		logic [9:0] data;
	} pvc_vid_s;
	// serial slave states
	typedef enum logic [5:0] {
		PVC_IDLE = 6'h01,
		PVC_RECV = 6'h02,
		PVC_ACK = 6'h04,
		PVC_SEND = 6'h08,
		PVC_MACK = 6'h10,
		PVC_MWAIT = 6'h20
	} pvc_i2c_e;
endpackage

/* design/pvc_top.sv */
// paged serial register bank and parallel video output port control
module pvc_top #(
	parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary serial address
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic pix_clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	input wire logic out_en_n_in,
	input wire logic standby_in,
	input wire pvc_pkg::pvc_src_s src_in,
	output pvc_pkg::pvc_vid_s vid_out,
	output logic imager_enable_out
);
	import pvc_pkg::*;

	// refuse the general call address
	if (DEV_ADDR == 7'h00) begin : g_chk
		$error("device address must be nonzero");
	end

	// serial side state, master clock domain
	typedef struct packed {
		logic rs1, rs2; // reset synchroniser
		logic scl1, scl2, scl3; // scl sync plus edge history
		logic sda1, sda2, sda3;
		logic sb1, sb2; // standby pin sync
		logic fa1, fa2; // frame active from link side
		pvc_i2c_e st;
		logic [3:0] cnt; // bit counter
		logic [7:0] sh; // shift register
		logic [1:0] byt; // byte index in a write
		logic rw; // 1: read transfer
		logic lo; // next read byte is the low one
		logic [7:0] ra; // register offset
		logic [7:0] hi; // high data byte
		logic [1:0] page; // selected page
		logic [CTRL_W-1:0] ctrl;
		logic [2:0][BANK_WORDS-1:0][15:0] bank;
		logic sda_oe_n;
		logic img_en;
	} pvc_cs_s;

	// one pipeline tap: framing plus formatted word
	typedef struct packed {
		logic frame;
		logic line;
		logic [9:0] w;
	} pvc_tap_s;

	// video side state, link clock domain
	typedef struct packed {
		logic rs1, rs2;
		logic [CTRL_W-1:0] cf1, cfs, cfh, cf2; // control word sync stages and agreed copy
		logic oe1, oe2; // enable pin sync
		logic sb1, sb2;
		logic ph; // half of the current beat
		logic bp; // byte or column phase
		logic row; // bayer row parity
		logic pl; // source line last beat
		logic [DLY-1:0] [11:0] tap;
		logic [2:0] mk; // marker bytes left
		logic eav; // marker ends a line
		pvc_vid_s vid;
	} pvc_ps_s;

	pvc_cs_s c_q, c_d;
	pvc_ps_s p_q, p_d;
	logic rise, fall, start, stop; // serial bus events
	logic load; // next read byte goes out
	logic pg_wr; // write hits page select
	logic [15:0] wval; // data word of a write
	logic [15:0] wd; // word at current offset
	logic [7:0] bsel; // byte of it to send
	logic sleep; // link side standby
	logic run; // pixel clock may toggle
	pvc_tap_s t4, t3, tn;

	// offset falls in plain storage
	function automatic logic in_bank(input logic [7:0] a);
		in_bank = a < 8'(BANK_WORDS);
	endfunction

	// read decode; page select reads back in every page
	function automatic logic [15:0] rd_word(input pvc_cs_s s);
		rd_word = 16'h0000;
		if (s.ra == PAGE_SEL_OFF) begin
			rd_word = {14'h0000, s.page};
		end else if (in_bank(s.ra)) begin
			rd_word = s.bank[s.page][s.ra[2:0]];
		end else if (s.page == PAGE_COLOR && s.ra == CTRL_OFF) begin
			rd_word = {8'h00, s.ctrl};
		end else if (s.page == PAGE_SENSOR && s.ra == STATUS_OFF) begin
			rd_word = {14'h0000, s.img_en, s.fa2};
		end
	endfunction

	// format one sample for the port
	function automatic logic [9:0] fmt_word(input pvc_src_s s, input logic [CTRL_W-1:0] cf,
			input logic bp, input logic row);
		logic [7:0] r, g, b;
		r = s.rgb[23:16];
		g = s.rgb[15:8];
		b = s.rgb[7:0];
		fmt_word = 10'h000;
		unique case (cf[CF_FMT +: FMT_W])
			FMT_YCC: fmt_word = {2'h0, s.ycc};
			FMT_565: fmt_word = bp ? {2'h0, g[4:2], b[7:3]} : {2'h0, r[7:3], g[7:5]};
			FMT_555: fmt_word = bp ? {2'h0, g[5:3], b[7:3]} : {3'h0, r[7:3], g[7:6]};
			FMT_444: fmt_word = bp ? {2'h0, b[7:4], 4'h0} : {2'h0, r[7:4], g[7:4]};
			FMT_RAW: fmt_word = cf[CF_W10] ? s.raw : {2'h0, s.raw[9:2]};
			FMT_PBAY: fmt_word = {2'h0, row ? (bp ? g : b) : (bp ? r : g)};
			default: fmt_word = 10'h000;
		endcase
	endfunction

	// serial slave next state
	always_comb begin
		c_d = c_q;
		c_d.rs1 = rst_n_in;
		c_d.rs2 = c_q.rs1;
		c_d.scl1 = scl_in;
		c_d.scl2 = c_q.scl1;
		c_d.scl3 = c_q.scl2;
		c_d.sda1 = sda_in;
		c_d.sda2 = c_q.sda1;
		c_d.sda3 = c_q.sda2;
		c_d.sb1 = standby_in;
		c_d.sb2 = c_q.sb1;
		c_d.fa1 = p_q.vid.frame;
		c_d.fa2 = c_q.fa1;
		// imager off on pin or register standby
		c_d.img_en = ~(c_q.sb2 | c_q.ctrl[CF_SLP]);
		rise = c_q.scl2 & ~c_q.scl3;
		fall = ~c_q.scl2 & c_q.scl3;
		start = c_q.scl2 & c_q.scl3 & ~c_q.sda2 & c_q.sda3;
		stop = c_q.scl2 & c_q.scl3 & c_q.sda2 & ~c_q.sda3;
		wd = rd_word(c_q);
		bsel = c_q.lo ? wd[7:0] : wd[15:8];
		wval = {c_q.hi, c_q.sh};
		pg_wr = 1'b0;
		load = 1'b0;
		if (stop) begin
			c_d.st = PVC_IDLE;
			c_d.sda_oe_n = 1'b1;
		end else if (start) begin
			c_d.st = PVC_RECV;
			c_d.cnt = 4'h0;
			c_d.byt = 2'h0;
			c_d.sda_oe_n = 1'b1;
		end else begin
			unique case (c_q.st)
				PVC_IDLE: begin
				end
				PVC_RECV: begin
					// address byte, then offset, then data high and low
					if (rise && c_q.cnt != BYTE_BITS) begin
						c_d.sh = {c_q.sh[6:0], c_q.sda2};
						c_d.cnt = c_q.cnt + 4'h1;
					end else if (fall && c_q.cnt == BYTE_BITS) begin
						c_d.st = PVC_ACK;
						c_d.sda_oe_n = 1'b0;
						unique case (c_q.byt)
							2'h0: begin
								if (c_q.sh[7:1] != DEV_ADDR) begin
									c_d.st = PVC_IDLE;
									c_d.sda_oe_n = 1'b1;
								end
								c_d.rw = c_q.sh[0];
								c_d.lo = 1'b0;
								c_d.byt = 2'h1;
							end
							2'h1: begin
								c_d.ra = c_q.sh;
								c_d.byt = 2'h2;
							end
							2'h2: begin
								c_d.hi = c_q.sh;
								c_d.byt = 2'h3;
							end
							default: begin
								// a word lands in the page held now
								if (c_q.ra == PAGE_SEL_OFF) begin
									pg_wr = 1'b1;
									if (wval < PAGE_LIMIT) begin
										c_d.page = wval[1:0];
									end
								end else if (in_bank(c_q.ra)) begin
									c_d.bank[c_q.page][c_q.ra[2:0]] = wval;
								end else if (c_q.page == PAGE_COLOR && c_q.ra == CTRL_OFF) begin
									c_d.ctrl = wval[CTRL_W-1:0];
								end
								c_d.ra = c_q.ra + 8'h01;
								c_d.byt = 2'h2;
							end
						endcase
					end
				end
				PVC_ACK: begin
					// release acknowledge; read goes on to send
					if (fall) begin
						c_d.sda_oe_n = 1'b1;
						c_d.st = PVC_RECV;
						c_d.cnt = 4'h0;
						load = c_q.rw;
					end
				end
				PVC_SEND: begin
					if (fall) begin
						if (c_q.cnt == BIT_LAST) begin
							c_d.st = PVC_MACK;
							c_d.sda_oe_n = 1'b1;
						end else begin
							c_d.sh = {c_q.sh[6:0], 1'b0};
							c_d.sda_oe_n = c_q.sh[6];
							c_d.cnt = c_q.cnt + 4'h1;
						end
					end
				end
				PVC_MACK: begin
					// host acknowledge: low continues, high ends
					if (rise) begin
						c_d.st = c_q.sda2 ? PVC_IDLE : PVC_MWAIT;
					end
				end
				PVC_MWAIT: begin
					load = fall;
				end
				default: begin
					c_d.st = PVC_IDLE;
				end
			endcase
		end
		// next read byte, high then low, offset steps after low
		if (load) begin
			c_d.st = PVC_SEND;
			c_d.sh = bsel;
			c_d.sda_oe_n = bsel[7];
			c_d.cnt = 4'h0;
			c_d.lo = ~c_q.lo;
			if (c_q.lo) begin
				c_d.ra = c_q.ra + 8'h01;
			end
		end
		// reset keeps synchronisers running
		if (!c_q.rs2) begin
			c_d.st = PVC_IDLE;
			c_d.cnt = 4'h0;
			c_d.sh = 8'h00;
			c_d.byt = 2'h0;
			c_d.rw = 1'b0;
			c_d.lo = 1'b0;
			c_d.ra = 8'h00;
			c_d.hi = 8'h00;
			c_d.page = PAGE_SENSOR;
			c_d.ctrl = CTRL_RST;
			c_d.bank = '0;
			c_d.sda_oe_n = 1'b1;
			c_d.img_en = 1'b0;
		end
	end

	// serial side register
	always_ff @(posedge clk_in) begin
		c_q <= c_d;
	end

	// video port next state
	always_comb begin
		p_d = p_q;
		p_d.rs1 = rst_n_in;
		p_d.rs2 = p_q.rs1;
		// word crosses as levels; taken only once two synced samples agree
		p_d.cf1 = c_q.ctrl;
		p_d.cfs = p_q.cf1;
		p_d.cfh = p_q.cfs;
		p_d.cf2 = (p_q.cfs == p_q.cfh) ? p_q.cfh : p_q.cf2;
		p_d.oe1 = out_en_n_in;
		p_d.oe2 = p_q.oe1;
		p_d.sb1 = standby_in;
		p_d.sb2 = p_q.sb1;
		sleep = p_q.sb2 | p_q.cf2[CF_SLP];
		run = p_q.cf2[CF_UNI] | p_q.vid.line | (p_q.mk != 3'h0);
		t4 = p_q.tap[DLY-1];
		t3 = p_q.tap[DLY-2];
		tn.frame = src_in.frame & ~sleep;
		tn.line = src_in.line & ~sleep;
		tn.w = fmt_word(src_in, p_q.cf2, p_q.bp, p_q.row);
		p_d.ph = ~p_q.ph;
		p_d.vid.oe_n = p_q.oe2 | p_q.cf2[CF_TRI];
		// high in second half of a beat, data steady then
		p_d.vid.pclk = ~p_q.ph & run & ~sleep;
		if (p_q.ph) begin
			p_d.tap = {p_q.tap[DLY-2:0], tn};
			p_d.bp = tn.line ? ~p_q.bp : 1'b0;
			p_d.row = ~tn.frame ? 1'b0 : (p_q.pl & ~tn.line) ? ~p_q.row : p_q.row;
			p_d.pl = tn.line;
			// markers fill the delay before a line and follow its end
			if (p_q.cf2[CF_EMB] && tn.line && !p_q.pl) begin
				p_d.mk = MK_LEN;
				p_d.eav = 1'b0;
			end else if (p_q.cf2[CF_EMB] && t4.line && !t3.line) begin
				p_d.mk = MK_LEN;
				p_d.eav = 1'b1;
			end else if (p_q.mk != 3'h0) begin
				p_d.mk = p_q.mk - 3'h1;
			end
			p_d.vid.frame = t4.frame;
			p_d.vid.line = t4.line;
			if (p_q.mk == MK_LEN) begin
				p_d.vid.data = {2'h0, MK_FF};
			end else if (p_q.mk != 3'h0 && p_q.mk != 3'h1) begin
				p_d.vid.data = {2'h0, MK_00};
			end else if (p_q.mk == 3'h1) begin
				// progressive: field bit zero, parity from v and h
				p_d.vid.data = {2'h0, 2'b10, ~t4.frame, p_q.eav, ~t4.frame ^ p_q.eav,
					p_q.eav, ~t4.frame, ~t4.frame ^ p_q.eav};
			end else begin
				p_d.vid.data = t4.line ? t4.w : 10'h000;
			end
		end
		if (!p_q.rs2) begin
			p_d.ph = 1'b0;
			p_d.bp = 1'b0;
			p_d.row = 1'b0;
			p_d.pl = 1'b0;
			p_d.tap = '0;
			p_d.cf2 = CTRL_RST;
			p_d.mk = 3'h0;
			p_d.eav = 1'b0;
			p_d.vid = '0;
			p_d.vid.oe_n = 1'b1;
		end
	end

	// video side register
	always_ff @(posedge pix_clk_in) begin
		p_q <= p_d;
	end

	assign sda_out = 1'b0 & c_q.sda_oe_n; // open drain: only ever pulls low
	assign sda_oe_n_out = c_q.sda_oe_n;
	assign imager_enable_out = c_q.img_en;
	assign vid_out = p_q.vid;

	// page takes the written value
	a_page_write: assert property (@(posedge clk_in) disable iff (!c_q.rs2)
		pg_wr && wval < PAGE_LIMIT |=> c_q.page == $past(wval[1:0]))
		else $error("page select write not taken");
	// page moves only by a page select write
	a_page_hold: assert property (@(posedge clk_in) disable iff (!c_q.rs2)
		!$stable(c_q.page) |-> $past(pg_wr))
		else $error("page changed without a write");
	// standby pin stops the imager
	a_standby_pin: assert property (@(posedge clk_in) disable iff (!c_q.rs2)
		c_q.sb2 |=> !c_q.img_en)
		else $error("imager running in standby");
	// enable pin high tri-states the port
	a_oe_pin: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		p_q.oe2 |=> p_q.vid.oe_n)
		else $error("outputs driven with enable off");
	// register tri-state
	a_oe_soft: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		p_q.cf2[CF_TRI] |=> p_q.vid.oe_n)
		else $error("outputs driven with tri-state bit set");
	// data steady at the pixel clock rise
	a_pclk_data: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		$rose(p_q.vid.pclk) |-> $stable(p_q.vid.data) && $stable(p_q.vid.line))
		else $error("data moved at pixel clock rise");
	// gated clock stays low outside lines and markers
	a_pclk_gated: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		!p_q.cf2[CF_UNI] && !p_q.vid.line && p_q.mk == 3'h0 |=> !p_q.vid.pclk)
		else $error("gated pixel clock toggled in blanking");
	// uniform clock toggles every beat
	a_pclk_uniform: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		p_q.cf2[CF_UNI] && !sleep && !p_q.ph |=> p_q.vid.pclk ##1 !p_q.vid.pclk)
		else $error("uniform pixel clock missing");
	// marker lasts four beats
	a_marker_len: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		$rose(p_q.mk != 3'h0) |-> (p_q.mk != 3'h0) [*8] ##1 (p_q.mk == 3'h0) || p_q.mk == MK_LEN)
		else $error("marker length wrong");
	// narrow port keeps the top bits low
	a_width8: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		!p_q.cf2[CF_W10] && !$changed(p_q.cf2) |=> p_q.vid.data[9:8] == 2'h0)
		else $error("eight-bit port drove upper bits");
	// raw samples pass unchanged
	a_raw_pass: assert property (@(posedge pix_clk_in) disable iff (!p_q.rs2)
		p_q.ph && p_q.cf2[CF_FMT +: FMT_W] == FMT_RAW && p_q.cf2[CF_W10]
		|=> p_q.tap[0][9:0] == $past(src_in.raw))
		else $error("raw sample altered");
	c_page: cover property (@(posedge clk_in) disable iff (!c_q.rs2) pg_wr);
	c_read: cover property (@(posedge clk_in) disable iff (!c_q.rs2) c_q.st == PVC_MWAIT);
	c_marker: cover property (@(posedge pix_clk_in) disable iff (!p_q.rs2) p_q.mk == MK_LEN);
	c_line: cover property (@(posedge pix_clk_in) disable iff (!p_q.rs2) $fell(p_q.vid.line));
endmodule

/* tb/pvc_host_model.sv */
// host model: serial register master and pixel-clock video capture
module pvc_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary serial address
	parameter int HALF = 8 // clk cycles per serial clock phase
) (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_oe_n_out,
	input wire pvc_pkg::pvc_vid_s vid_in,
	output logic [9:0] cap_data_out,
	output int cap_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import pvc_pkg::*;
	// bus released and idle at time zero
	initial begin
		scl_out = 1'b1;
		sda_oe_n_out = 1'b1;
		cap_data_out = '0;
		cap_count_out = 0;
	end
	// one serial clock phase
	task automatic half_wait();
		repeat (HALF) @(negedge clk_in);
	endtask
	// one bit: data moves only while the serial clock is low
	task automatic bit_io(input logic b, output logic s);
		repeat (2) @(negedge clk_in);
		sda_oe_n_out = b; // low pulls the wire, high releases it
		half_wait();
		scl_out = 1'b1;
		half_wait();
		s = sda_in;
		scl_out = 1'b0;
	endtask
	// start: data falls while the clock is high
	task automatic start_cond();
		sda_oe_n_out = 1'b1;
		half_wait();
		scl_out = 1'b1;
		half_wait();
		sda_oe_n_out = 1'b0;
		half_wait();
		scl_out = 1'b0;
	endtask
	// stop: data rises while the clock is high
	task automatic stop_cond();
		repeat (2) @(negedge clk_in);
		sda_oe_n_out = 1'b0;
		half_wait();
		scl_out = 1'b1;
		half_wait();
		sda_oe_n_out = 1'b1;
		half_wait();
	endtask
	// eight bits msb first, then the acknowledge bit
	task automatic xfer_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], s);
			rx[i] = s;
		end
		bit_io(last, ack);
	endtask
	// write: address, offset, then the word high byte first
	task automatic write_reg(input logic [7:0] off, input logic [15:0] val, output logic nak);
		logic [7:0] rx;
		logic a0;
		logic a1;
		logic a2;
		logic a3;
		start_cond();
		xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
		xfer_byte(off, 1'b1, rx, a1);
		xfer_byte(val[15:8], 1'b1, rx, a2);
		xfer_byte(val[7:0], 1'b1, rx, a3);
		stop_cond();
		nak = a0 | a1 | a2 | a3;
	endtask
	// read: set the offset, stop, then start again and fetch one word
	task automatic read_reg(input logic [7:0] off, output logic [15:0] val);
		logic [7:0] rx;
		logic a;
		start_cond();
		xfer_byte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
		xfer_byte(off, 1'b1, rx, a);
		stop_cond();
		start_cond();
		xfer_byte({DEV_ADDR, 1'b1}, 1'b1, rx, a);
		xfer_byte(8'hFF, 1'b0, val[15:8], a); // host acks to go on
		xfer_byte(8'hFF, 1'b1, val[7:0], a); // host nacks to end
		stop_cond();
	endtask
	// capture on the pixel clock, only while a line is marked active
	always @(posedge vid_in.pclk) begin
		if (vid_in.line && !vid_in.oe_n) begin
			cap_data_out <= vid_in.data;
			cap_count_out <= cap_count_out + 1;
		end
	end
endmodule

/* tb/test_paged_register_and_video_port_control.sv */
// self-checking bench for the paged register and video port control block
module test_paged_register_and_video_port_control;
	timeunit 1ns;
	timeprecision 1ps;
	import pvc_pkg::*;
	typedef struct packed {
		logic [15:0] page;
		logic [7:0] off;
		logic [15:0] val;
	} pvc_row_s;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [9:0] last;
	} pvc_fmt_s;
	logic clk_in = 1'b0;
	logic pix_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic out_en_n_in = 1'b0;
	logic standby_in = 1'b0;
	pvc_src_s src_in = '0;
	pvc_vid_s vid_out;
	logic scl;
	logic host_oe_n;
	logic dev_oe_n;
	logic dev_sda;
	logic imager_enable_out;
	logic [9:0] cap_data;
	int cap_count;
	int bad_count = 0;
	int check_count = 0;
	int pclk_edges = 0;
	logic frame_seen = 1'b0;
	wire logic sda_wire = dev_oe_n & host_oe_n; // pull-up unless someone pulls
	pvc_row_s rows [5] = '{'{16'h0, 8'h06, 16'h1111}, '{16'h1, 8'h06, 16'h2222},
		'{16'h2, 8'h06, 16'h3333}, '{16'h2, 8'h00, 16'hAAAA}, '{16'h0, 8'h07, 16'h5A5A}};
	// format and the last byte of the constant test line, a second byte of its pair
	pvc_fmt_s fmts [5] = '{'{{13'h0, FMT_565}, 10'h02B}, '{{13'h0, FMT_555}, 10'h08B},
		'{{13'h0, FMT_444}, 10'h050}, '{{13'h0, FMT_PBAY}, 10'h0C3}, '{{13'h0, FMT_RAW}, 10'h0A9}};
	// master clock and unrelated link clock
	always #12.5 clk_in = ~clk_in;
	always begin
		#7;
		forever #24 pix_clk_in = ~pix_clk_in;
	end
	pvc_top uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .pix_clk_in(pix_clk_in),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(dev_sda), .sda_oe_n_out(dev_oe_n),
		.out_en_n_in(out_en_n_in), .standby_in(standby_in), .src_in(src_in),
		.vid_out(vid_out), .imager_enable_out(imager_enable_out));
	pvc_host_model host (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
		.sda_oe_n_out(host_oe_n), .vid_in(vid_out), .cap_data_out(cap_data),
		.cap_count_out(cap_count));
	// monitors of the video port
	always @(posedge vid_out.pclk) pclk_edges++;
	always @(posedge pix_clk_in) if (vid_out.frame === 1'b1) frame_seen <= 1'b1;
	// compare and count
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] off, input logic [15:0] val);
		logic nak;
		host.write_reg(off, val, nak);
		check("write ack", 16'h0000, {15'h0, nak});
	endtask
	task automatic rd(input string what, input logic [7:0] off, input logic [15:0] exp);
		logic [15:0] got;
		host.read_reg(off, got);
		check(what, exp, got);
	endtask
	// one video line of constant samples, driven on the link clock
	task automatic run_line(input int beats);
		@(negedge pix_clk_in);
		src_in = '{frame: 1'b1, line: 1'b1, raw: 10'h2A5, rgb: 24'hC3A55A, ycc: 8'h5C};
		repeat (2 * beats) @(negedge pix_clk_in);
		src_in.line = 1'b0;
		repeat (40) @(negedge pix_clk_in);
		src_in.frame = 1'b0;
		repeat (20) @(negedge pix_clk_in);
	endtask
	// watchdog
	initial begin
		#2_000_000;
		bad_count++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (10) @(negedge clk_in);
		check("sda during reset", 16'h1, {15'h0, dev_oe_n});
		check("imager in reset", 16'h0, {15'h0, imager_enable_out});
		check("port in reset", 16'h1, {15'h0, vid_out.oe_n});
		check("sda value", 16'h0, {15'h0, dev_sda});
		rst_n_in = 1'b1;
		repeat (6) @(negedge clk_in);
		rd("page reset", PAGE_SEL_OFF, 16'h0000);
		rd("status", STATUS_OFF, 16'h0002);
		// table of page, offset and word
		foreach (rows[i]) begin
			wr(PAGE_SEL_OFF, rows[i].page);
			wr(rows[i].off, rows[i].val);
			rd("page", PAGE_SEL_OFF, rows[i].page);
			rd("word", rows[i].off, rows[i].val);
		end
		// pages stay apart and the page holds
		rd("page0 word6", 8'h06, 16'h1111);
		wr(PAGE_SEL_OFF, {14'h0, PAGE_CAMCTL});
		rd("page2 word6", 8'h06, 16'h3333);
		rd("page2 word0", 8'h00, 16'hAAAA);
		wr(PAGE_SEL_OFF, PAGE_LIMIT);
		rd("bad page kept", PAGE_SEL_OFF, 16'h0002);
		rd("unmapped", 8'h40, 16'h0000);
		// standby by pin, then by register
		standby_in = 1'b1;
		repeat (20) @(negedge clk_in);
		check("imager standby pin", 16'h0, {15'h0, imager_enable_out});
		standby_in = 1'b0;
		wr(PAGE_SEL_OFF, {14'h0, PAGE_COLOR});
		rd("control reset", CTRL_OFF, {8'h00, CTRL_RST});
		wr(CTRL_OFF, 16'h1 << CF_SLP);
		repeat (20) @(negedge clk_in);
		check("imager standby reg", 16'h0, {15'h0, imager_enable_out});
		rd("control", CTRL_OFF, 16'h0040);
		// tri-state by pin, then by register
		wr(CTRL_OFF, 16'h0000);
		out_en_n_in = 1'b1;
		repeat (20) @(negedge clk_in);
		check("port off pin", 16'h1, {15'h0, vid_out.oe_n});
		out_en_n_in = 1'b0;
		repeat (20) @(negedge clk_in);
		check("port on pin", 16'h0, {15'h0, vid_out.oe_n});
		wr(CTRL_OFF, 16'h1 << CF_TRI);
		repeat (20) @(negedge clk_in);
		check("port off reg", 16'h1, {15'h0, vid_out.oe_n});
		// raw ten-bit gated video
		wr(CTRL_OFF, (16'h1 << CF_W10) | {13'h0, FMT_RAW});
		run_line(16);
		check("raw sample", 16'h02A5, {6'h0, cap_data});
		check("captured", 16'h1, {15'h0, cap_count > 0});
		check("frame marked", 16'h1, {15'h0, frame_seen});
		pclk_edges = 0;
		repeat (40) @(negedge pix_clk_in);
		check("gated idle pclk", 16'h0, pclk_edges[15:0]);
		// uniform clock, then embedded markers
		wr(CTRL_OFF, (16'h1 << CF_UNI) | {13'h0, FMT_RAW});
		pclk_edges = 0;
		repeat (40) @(negedge pix_clk_in);
		check("uniform pclk", 16'h1, {15'h0, pclk_edges > 10});
		wr(CTRL_OFF, (16'h1 << CF_EMB) | {13'h0, FMT_YCC});
		run_line(16);
		check("embedded sample", 16'h005C, {8'h0, cap_data[7:0]});
		// remaining formats, gated clock, eight-bit port
		foreach (fmts[i]) begin
			wr(CTRL_OFF, fmts[i].ctrl);
			run_line(16);
			check("format last byte", {6'h0, fmts[i].last}, {6'h0, cap_data});
		end
		// reset again mid-run: page and outputs return to their reset state
		rst_n_in = 1'b0;
		repeat (10) @(negedge clk_in);
		check("imager in mid reset", 16'h0, {15'h0, imager_enable_out});
		check("port in mid reset", 16'h1, {15'h0, vid_out.oe_n});
		rst_n_in = 1'b1;
		repeat (6) @(negedge clk_in);
		rd("page after mid reset", PAGE_SEL_OFF, 16'h0000);
		report_and_stop();
	end
endmodule
